// >>> rtl/fault_retry_and_turn_on_sequencer.sv
// Turn-on sequencer with fault retry, power-good and settings
//
// Overview of operation
// RULE1: Retry field 4, 5 or 6 gives exactly that many restarts.
// RULE2: When all restarts fail the output stays off until cleared.
// RULE3: Restart starts are spaced by the timing field times the unit; the code spaces them by 2 to the power n delay units.
// RULE4: Retry field 7 retries until off, bias loss or another fault.
// RULE5: Timing field n selects 2 to the power n delay units.
// RULE6: The same count is the run-on time or the restart spacing.
// RULE7: The delay unit comes from the time unit setting at D2.
// RULE8: Power-good asserts when the output reaches the assert level.
// RULE9: Below the negate level power-good drops and status sets.
// RULE10: The turn-on wait runs from enable to the start of the rise.
// RULE11: After the wait the output ramps for the rise time.
// RULE12: Level and timing settings are 16-bit word accesses.
// RULE13: The response field picks ignore, run-on, retry or hold.
// RULE14: A held fault clears by bit clear, clear-all or off then on.
// RULE15: The attempt count restarts on clear or on a good restart.
`timescale 1ns/1ns
module fault_retry_and_turn_on_sequencer #(
	parameter int CYCLES_PER_MS = fault_seq_pkg::CYCLES_PER_MS
)
(
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        cmd_valid_in,
	input  wire logic        cmd_write_in,
	input  wire logic        cmd_word_in,
	input  wire logic [7:0]  cmd_code_in,
	input  wire logic [15:0] cmd_wdata_in,
	output logic [15:0]      cmd_rdata_out,
	output logic             cmd_ack_out,
	output logic             cmd_err_out,
	input  wire logic [15:0] vout_in,
	input  wire logic        fault_in,
	input  wire logic        other_fault_in,
	input  wire logic        on_cmd_in,
	input  wire logic        bias_ok_in,
	input  wire logic        clear_faults_in,
	input  wire logic        clear_fault_bit_in,
	input  wire logic        multi_pin_setup_pg_in,
	output logic             out_enable_out,
	output logic             ramp_active_out,
	output logic             supply_ok_output_out,
	output logic             pg_status_out,
	output logic             fault_latched_out,
	output logic [2:0]       attempts_out
);
	// ==========================================================
	// Settings
	logic [15:0] pg_on_r;
	logic [15:0] pg_off_r;
	logic [15:0] ton_wait_r;
	logic [15:0] ton_ramp_r;
	logic [7:0]  act_r;
	logic [7:0]  unit_r;

	wire hit_on   = (cmd_code_in == fault_seq_pkg::CMD_PG_ON);
	wire hit_off  = (cmd_code_in == fault_seq_pkg::CMD_PG_OFF);
	wire hit_wait = (cmd_code_in == fault_seq_pkg::CMD_TON_WAIT);
	wire hit_ramp = (cmd_code_in == fault_seq_pkg::CMD_TON_RAMP);
	wire hit_act  = (cmd_code_in == fault_seq_pkg::CMD_FAULT_ACT);
	wire hit_unit = (cmd_code_in == fault_seq_pkg::CMD_TIME_UNIT);
	wire hit_word = hit_on | hit_off | hit_wait | hit_ramp;
	wire hit_byte = hit_act | hit_unit;
	wire acc_ok   = (hit_word & cmd_word_in) | (hit_byte & ~cmd_word_in); // see RULE12
	wire wr_ok    = cmd_valid_in & cmd_write_in & acc_ok;
	wire rd_ok    = cmd_valid_in & ~cmd_write_in & acc_ok;

	logic [15:0] rd_mux;
	assign rd_mux = hit_on   ? pg_on_r :
	                hit_off  ? pg_off_r :
	                hit_wait ? ton_wait_r :
	                hit_ramp ? ton_ramp_r :
	                hit_act  ? {8'h00, act_r} :
	                           {8'h00, unit_r};

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pg_on_r    <= fault_seq_pkg::RST_WORD;
			pg_off_r   <= fault_seq_pkg::RST_WORD;
			ton_wait_r <= fault_seq_pkg::RST_WORD;
			ton_ramp_r <= fault_seq_pkg::RST_WORD;
			act_r      <= fault_seq_pkg::RST_ACT;
			unit_r     <= fault_seq_pkg::RST_UNIT;
		end
		else if (wr_ok)
		begin
			if (hit_on)
				pg_on_r <= cmd_wdata_in; // see RULE12
			if (hit_off)
				pg_off_r <= cmd_wdata_in;
			if (hit_wait)
				ton_wait_r <= cmd_wdata_in;
			if (hit_ramp)
				ton_ramp_r <= cmd_wdata_in;
			if (hit_act)
				act_r <= cmd_wdata_in[7:0];
			if (hit_unit)
				unit_r <= cmd_wdata_in[7:0]; // see RULE7
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cmd_ack_out   <= 1'b0;
			cmd_err_out   <= 1'b0;
			cmd_rdata_out <= fault_seq_pkg::RST_DATA;
		end
		else
		begin
			cmd_ack_out <= cmd_valid_in;
			cmd_err_out <= cmd_valid_in & ~acc_ok;
			if (rd_ok)
				cmd_rdata_out <= rd_mux;
		end
	end

	// ==========================================================
	// Timers
	logic tick;
	timer_if rt ();
	timer_if st ();

	ms_tick_div #(.DIV(CYCLES_PER_MS)) u_tick
	(
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.tick_out (tick)
	);
	ms_timer u_retry_tmr
	(
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.tick_in  (tick),
		.t        (rt.tmr)
	);
	ms_timer u_seq_tmr
	(
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.tick_in  (tick),
		.t        (st.tmr)
	);

	// ==========================================================
	// Fault decode
	fault_seq_pkg::state_t state_r;
	fault_seq_pkg::state_t state_nxt;
	logic [2:0]            attempts_r;

	fault_seq_pkg::resp_t resp;
	assign resp = fault_seq_pkg::resp_t'(act_r[fault_seq_pkg::RESP_HI:
		fault_seq_pkg::RESP_LO]); // see RULE13
	wire [2:0] retry_f = act_r[fault_seq_pkg::RETRY_HI:fault_seq_pkg::RETRY_LO];
	wire [2:0] time_f  = act_r[fault_seq_pkg::TIME_HI:fault_seq_pkg::TIME_LO];
	wire [15:0] gap_ms = fault_seq_pkg::interval_ms(time_f, unit_r); // see RULE5

	wire run_ok   = on_cmd_in & bias_ok_in;
	wire out_live = (state_r == fault_seq_pkg::S_RISE) |
	                (state_r == fault_seq_pkg::S_ON) |
	                (state_r == fault_seq_pkg::S_FRUN);
	wire trip     = out_live & fault_in & (state_r != fault_seq_pkg::S_FRUN);
	wire no_limit = (retry_f == fault_seq_pkg::RETRY_FOREVER);
	wire may_retry = no_limit | ((retry_f != fault_seq_pkg::RETRY_NONE) &
	                 (attempts_r < retry_f)); // see RULE1
	wire shut_evt = (trip & resp == fault_seq_pkg::RESP_RETRY) |
	                ((state_r == fault_seq_pkg::S_FRUN) & rt.done & fault_in);
	wire start_evt = (state_r == fault_seq_pkg::S_RETRY) & ~rt.busy &
	                 run_ok & ~other_fault_in;
	wire success  = (state_r == fault_seq_pkg::S_RISE) & st.done & ~fault_in;
	wire clr_evt  = clear_faults_in | clear_fault_bit_in;

	// ==========================================================
	// Sequencer
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			fault_seq_pkg::S_OFF:
				if (run_ok)
					state_nxt = fault_seq_pkg::S_DELAY;
			fault_seq_pkg::S_DELAY:
				if (st.done)
					state_nxt = fault_seq_pkg::S_RISE; // see RULE10
			fault_seq_pkg::S_RISE, fault_seq_pkg::S_ON:
				if (trip && resp == fault_seq_pkg::RESP_RUN)
					state_nxt = fault_seq_pkg::S_FRUN; // see RULE6
				else if (trip && resp == fault_seq_pkg::RESP_HOLD)
					state_nxt = fault_seq_pkg::S_LATCH;
				else if (shut_evt)
					state_nxt = may_retry ? fault_seq_pkg::S_RETRY :
						fault_seq_pkg::S_LATCH; // see RULE2
				else if (success)
					state_nxt = fault_seq_pkg::S_ON; // see RULE11
			fault_seq_pkg::S_FRUN:
				if (shut_evt)
					state_nxt = may_retry ? fault_seq_pkg::S_RETRY :
						fault_seq_pkg::S_LATCH;
				else if (rt.done)
					state_nxt = fault_seq_pkg::S_ON;
			fault_seq_pkg::S_RETRY:
				if (start_evt)
					state_nxt = fault_seq_pkg::S_DELAY; // see RULE3
			fault_seq_pkg::S_LATCH:
				if (clr_evt)
					state_nxt = fault_seq_pkg::S_OFF; // see RULE14
			default:
				state_nxt = fault_seq_pkg::S_OFF;
		endcase
		if (other_fault_in && state_r != fault_seq_pkg::S_OFF)
			state_nxt = fault_seq_pkg::S_LATCH; // see RULE4
		if (!run_ok)
			state_nxt = fault_seq_pkg::S_OFF; // see RULE14
	end

	// Spacing counts from the shutdown, then from each attempt start
	assign rt.load = ((state_nxt == fault_seq_pkg::S_FRUN) &
	                  (state_r != fault_seq_pkg::S_FRUN)) |
	                 (shut_evt & ~rt.busy) | start_evt; // see RULE3
	assign rt.load_ms = gap_ms; // see RULE6
	assign st.load = ((state_nxt == fault_seq_pkg::S_DELAY) &
	                  (state_r != fault_seq_pkg::S_DELAY)) |
	                 ((state_nxt == fault_seq_pkg::S_RISE) &
	                  (state_r == fault_seq_pkg::S_DELAY));
	assign st.load_ms = (state_r == fault_seq_pkg::S_DELAY) ? ton_ramp_r :
		ton_wait_r;

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			state_r <= fault_seq_pkg::S_OFF;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			attempts_r <= 3'h0;
		else if (state_nxt == fault_seq_pkg::S_OFF || success)
			attempts_r <= 3'h0; // see RULE15
		else if (start_evt && !no_limit)
			attempts_r <= attempts_r + 3'h1; // see RULE1
	end

	// ==========================================================
	// Power good
	logic pg_r;
	logic pg_stat_r;
	wire  pg_fall = pg_r & (vout_in < pg_off_r);
	wire  pg_rise = ~pg_r & out_live & multi_pin_setup_pg_in &
	                (vout_in >= pg_on_r);

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pg_r      <= 1'b0;
			pg_stat_r <= 1'b0;
		end
		else
		begin
			if (pg_fall || !out_live || !multi_pin_setup_pg_in)
				pg_r <= 1'b0; // see RULE9
			else if (pg_rise)
				pg_r <= 1'b1; // see RULE8
			if (pg_fall)
				pg_stat_r <= 1'b1; // see RULE9
			else if (clear_faults_in)
				pg_stat_r <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			out_enable_out    <= 1'b0;
			ramp_active_out   <= 1'b0;
			fault_latched_out <= 1'b0;
		end
		else
		begin
			out_enable_out    <= (state_nxt == fault_seq_pkg::S_RISE) |
			                     (state_nxt == fault_seq_pkg::S_ON) |
			                     (state_nxt == fault_seq_pkg::S_FRUN);
			ramp_active_out   <= (state_nxt == fault_seq_pkg::S_RISE);
			fault_latched_out <= (state_nxt == fault_seq_pkg::S_LATCH);
		end
	end

	assign supply_ok_output_out = pg_r;
	assign pg_status_out        = pg_stat_r;
	assign attempts_out         = attempts_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_run_on;
		state_r == fault_seq_pkg::S_ON && fault_in && run_ok &&
		!other_fault_in && resp == fault_seq_pkg::RESP_RUN;
	endsequence
	sequence s_kept_on;
		state_r == fault_seq_pkg::S_FRUN ##1 out_enable_out;
	endsequence

	retry_bound_a: assert property ( // see RULE1
		(!no_limit && retry_f != fault_seq_pkg::RETRY_NONE) |->
		attempts_r <= retry_f)
		else $error("attempt count above retry setting");
	give_up_a: assert property ( // see RULE2
		(shut_evt && !may_retry && run_ok && !other_fault_in) |=>
		state_r == fault_seq_pkg::S_LATCH [*2])
		else $error("exhausted retries did not hold off");
	spacing_load_a: assert property ( // see RULE3
		start_evt |-> rt.load && rt.load_ms == gap_ms ##1 rt.busy)
		else $error("attempt start did not restart spacing");
	endless_retry_a: assert property ( // see RULE4
		(shut_evt && no_limit && run_ok && !other_fault_in) |=>
		state_r == fault_seq_pkg::S_RETRY)
		else $error("continuous retry stopped");
	unit_scale_a: assert property ( // see RULE5
		(unit_r == 8'h01) |-> gap_ms == (16'h0001 << time_f))
		else $error("timing field scale wrong");
	run_on_a: assert property ( // see RULE6
		s_run_on |=> s_kept_on)
		else $error("run-on response dropped output");
	pg_assert_a: assert property ( // see RULE8
		$rose(supply_ok_output_out) |-> $past(vout_in) >= $past(pg_on_r))
		else $error("power good rose below assert level");
	pg_status_a: assert property ( // see RULE9
		pg_fall |=> !supply_ok_output_out && pg_status_out)
		else $error("power good fall not reported");
	wait_first_a: assert property ( // see RULE10
		(state_r == fault_seq_pkg::S_DELAY && !st.done) |=>
		!ramp_active_out)
		else $error("rise started before turn-on wait");
	hold_mode_a: assert property ( // see RULE13
		(trip && resp == fault_seq_pkg::RESP_HOLD && run_ok) |=>
		fault_latched_out)
		else $error("hold response did not latch");
	clear_latch_a: assert property ( // see RULE14
		(state_r == fault_seq_pkg::S_LATCH && clr_evt &&
		!other_fault_in) |=>
		state_r == fault_seq_pkg::S_OFF && !fault_latched_out)
		else $error("fault clear ignored");
	fresh_count_a: assert property ( // see RULE15
		(success && run_ok && !other_fault_in) |=> attempts_r == 3'h0)
		else $error("attempt count kept after good restart");

endmodule // fault_retry_and_turn_on_sequencer

// >>> rtl/fault_seq_pkg.sv
// Constants, types and helpers shared by the sequencer design
package fault_seq_pkg;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_FAULT_ACT = 8'h5A;
	localparam logic [7:0] CMD_PG_ON     = 8'h5E;
	localparam logic [7:0] CMD_PG_OFF    = 8'h5F;
	localparam logic [7:0] CMD_TON_WAIT  = 8'h60;
	localparam logic [7:0] CMD_TON_RAMP  = 8'h61;
	localparam logic [7:0] CMD_TIME_UNIT = 8'hD2;

	// ==========================================================
	// Fault action field positions
	localparam int RESP_HI  = 7;
	localparam int RESP_LO  = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int TIME_HI  = 2;
	localparam int TIME_LO  = 0;

	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ==========================================================
	// Reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0]  RST_ACT  = 8'h00;
	localparam logic [7:0]  RST_UNIT = 8'h01;
	localparam logic [15:0] RST_DATA = 16'h0000;

	// ==========================================================
	// Timing
	localparam longint CLK_HZ        = 125000000;
	localparam longint TICK_MS       = 1;
	localparam int     CYCLES_PER_MS = int'((CLK_HZ * TICK_MS) / 1000);

	// ==========================================================
	// Types
	typedef enum logic [1:0]
	{
		RESP_IGNORE,
		RESP_RUN,
		RESP_RETRY,
		RESP_HOLD
	} resp_t;

	typedef enum logic [2:0]
	{
		S_OFF,
		S_DELAY,
		S_RISE,
		S_ON,
		S_FRUN,
		S_RETRY,
		S_LATCH
	} state_t;

	// Delay in ms: 2**n units; a zero unit counts as one ms
	function automatic logic [15:0] interval_ms(input logic [2:0] n,
		input logic [7:0] unit);
		logic [15:0] u;
		u = (unit == 8'h00) ? 16'h0001 : {8'h00, unit};
		return u << n;
	endfunction

endpackage

// >>> rtl/timer_if.sv
// Load and completion signals between the sequencer and a ms timer
`timescale 1ns/1ns
interface timer_if;
	logic        load;
	logic [15:0] load_ms;
	logic        busy;
	logic        done;

	modport ctl (output load, output load_ms, input busy, input done);
	modport tmr (input load, input load_ms, output busy, output done);
endinterface // timer_if

// >>> rtl/ms_tick_div.sv
// Divider giving a one-cycle enable pulse every millisecond
`timescale 1ns/1ns
module ms_tick_div #(
	parameter int DIV = fault_seq_pkg::CYCLES_PER_MS
)
(
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	output logic      tick_out
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] cnt_r;
	wire           wrap = (cnt_r == CW'(DIV - 1));

	// ==========================================================
	// Free running count
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt_r    <= '0;
			tick_out <= 1'b0;
		end
		else
		begin
			cnt_r    <= wrap ? '0 : cnt_r + CW'(1);
			tick_out <= wrap;
		end
	end
endmodule // ms_tick_div

// >>> rtl/ms_timer.sv
// Millisecond countdown timer with load, busy and done
`timescale 1ns/1ns
module ms_timer
(
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic tick_in,
	timer_if.tmr      t
);
	logic [15:0] cnt_r;

	// ==========================================================
	// Countdown
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt_r  <= 16'h0000;
			t.busy <= 1'b0;
			t.done <= 1'b0;
		end
		else if (t.load)
		begin
			cnt_r  <= t.load_ms;
			t.busy <= 1'b1;
			t.done <= 1'b0;
		end
		else if (t.busy && cnt_r == 16'h0000)
		begin
			t.busy <= 1'b0;
			t.done <= 1'b1;
		end
		else
		begin
			t.done <= 1'b0;
			if (t.busy && tick_in)
				cnt_r <= cnt_r - 16'h0001;
		end
	end
endmodule // ms_timer

// >>> tb/pmbus_host_model.sv
// Host controller model that drives the command port
`timescale 1ns/1ns
module pmbus_host_model
(
	input  wire logic        clk_in,
	output logic             cmd_valid_out,
	output logic             cmd_write_out,
	output logic             cmd_word_out,
	output logic [7:0]       cmd_code_out,
	output logic [15:0]      cmd_wdata_out,
	input  wire logic [15:0] cmd_rdata_in,
	input  wire logic        cmd_ack_in,
	input  wire logic        cmd_err_in
);
	initial
	begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_word_out  = 1'b0;
		cmd_code_out  = 8'h00;
		cmd_wdata_out = 16'h0000;
	end

	// ==========================================================
	// One access, words as one 16-bit transfer
	task automatic xfer(input logic wr, input logic wd, input logic [7:0] c,
		input logic [15:0] d, output logic er, output logic [15:0] rd,
		output logic ok);
		int i;
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = wr;
		cmd_word_out  = wd;
		cmd_code_out  = c;
		cmd_wdata_out = d;
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		for (i = 0; i < 4 && cmd_ack_in !== 1'b1; i++)
			@(negedge clk_in);
		ok = (cmd_ack_in === 1'b1);
		er = cmd_err_in;
		rd = cmd_rdata_in;
		// Released lines do not keep their last value
		cmd_code_out  = ~c;
		cmd_wdata_out = ~d;
	endtask
endmodule // pmbus_host_model

// >>> tb/tb_fault_retry_and_turn_on_sequencer.sv
// Self-checking bench for the turn-on and fault retry sequencer
`timescale 1ns/1ns
module tb_fault_retry_and_turn_on_sequencer;
	localparam int CPM = 10;
	logic        clk_in, rst_b_in, cmd_valid, cmd_write, cmd_word;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, vout_in;
	logic        cmd_ack, cmd_err, fault_in, other_fault_in, on_cmd_in;
	logic        bias_ok_in, clear_faults_in, clear_fault_bit_in;
	logic        multi_pin_setup_pg_in, out_en, ramp, pg, pg_stat, latched;
	logic [2:0]  attempts;
	int          err_count, tests_run;

	fault_retry_and_turn_on_sequencer #(.CYCLES_PER_MS(CPM)) dut
	(
		.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid),
		.cmd_write_in(cmd_write), .cmd_word_in(cmd_word),
		.cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata),
		.cmd_rdata_out(cmd_rdata), .cmd_ack_out(cmd_ack),
		.cmd_err_out(cmd_err), .vout_in(vout_in), .fault_in(fault_in),
		.other_fault_in(other_fault_in), .on_cmd_in(on_cmd_in),
		.bias_ok_in(bias_ok_in), .clear_faults_in(clear_faults_in),
		.clear_fault_bit_in(clear_fault_bit_in),
		.multi_pin_setup_pg_in(multi_pin_setup_pg_in),
		.out_enable_out(out_en), .ramp_active_out(ramp),
		.supply_ok_output_out(pg), .pg_status_out(pg_stat),
		.fault_latched_out(latched), .attempts_out(attempts)
	);

	pmbus_host_model host
	(
		.clk_in(clk_in), .cmd_valid_out(cmd_valid),
		.cmd_write_out(cmd_write), .cmd_word_out(cmd_word),
		.cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata),
		.cmd_rdata_in(cmd_rdata), .cmd_ack_in(cmd_ack), .cmd_err_in(cmd_err)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// ==========================================================
	// Checks and helpers
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi,
		input int g);
		tests_run++;
		if (g < lo || g > hi)
		begin
			err_count++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return out_en;
			1: return ramp;
			default: return latched;
		endcase
	endfunction

	task automatic wait_sig(input int k, input logic v, input int lim,
		output int n);
		for (n = 0; sig(k) !== v && n < lim; n++)
			@(negedge clk_in);
		if (sig(k) !== v)
		begin
			err_count++;
			$display("mismatch wait %0d expected %b seen timeout", k, v);
			conclude();
		end
	endtask

	task automatic acc(input logic wr, input logic wd, input logic [7:0] c,
		input logic [15:0] d, input logic e, output logic [15:0] rd);
		logic er;
		logic ok;
		host.xfer(wr, wd, c, d, er, rd, ok);
		chk("ack", 16'h0001, {15'h0000, ok});
		chk("err", {15'h0000, e}, {15'h0000, er});
		if (!ok)
			conclude();
	endtask

	task automatic wr(input logic [7:0] c, input logic wd, input logic [15:0] d);
		logic [15:0] r;
		acc(1'b1, wd, c, d, 1'b0, r);
	endtask

	task automatic rdc(input logic [7:0] c, input logic wd, input logic [15:0] e);
		logic [15:0] r;
		acc(1'b0, wd, c, 16'h0000, 1'b0, r);
		chk("rdata", e, r);
	endtask

	task automatic clr(input logic all);
		clear_faults_in = all;
		clear_fault_bit_in = ~all;
		@(negedge clk_in);
		clear_faults_in = 1'b0;
		clear_fault_bit_in = 1'b0;
	endtask

	task automatic power_on();
		int n;
		on_cmd_in = 1'b1;
		wait_sig(0, 1'b1, 40 * CPM, n);
		wait_sig(1, 1'b0, 40 * CPM, n);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin : main
		int k, n, w, rr, t, cnt, last, iv, u;
		logic [15:0] d[4];
		logic [15:0] r;
		logic [2:0] prev;
		logic pe;
		rst_b_in = 1'b0;
		vout_in = 16'h0000;
		fault_in = 1'b0;
		other_fault_in = 1'b0;
		on_cmd_in = 1'b0;
		bias_ok_in = 1'b1;
		clear_faults_in = 1'b0;
		clear_fault_bit_in = 1'b0;
		multi_pin_setup_pg_in = 1'b1;
		err_count = 0;
		tests_run = 0;
		void'($urandom(32'hB5B646F1));
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		rst_b_in = 1'b1;

		for (k = 0; k < 4; k++)
			rdc(8'h5E + 8'(k), 1'b1, 16'h0000);
		rdc(8'h5A, 1'b0, 16'h0000);
		rdc(8'hD2, 1'b0, 16'h0001);
		for (k = 0; k < 4; k++)
		begin
			d[k] = 16'($urandom);
			wr(8'h5E + 8'(k), 1'b1, d[k]);
			rdc(8'h5E + 8'(k), 1'b1, d[k]);
		end
		acc(1'b1, 1'b0, 8'h60, 16'h0005, 1'b1, r);
		acc(1'b1, 1'b1, 8'h5A, 16'h0005, 1'b1, r);
		acc(1'b0, 1'b1, 8'h33, 16'h0000, 1'b1, r);
		rdc(8'h60, 1'b1, d[2]);
		$display("test registers done");

		w = 2 + int'($urandom % 3);
		rr = 2 + int'($urandom % 3);
		wr(8'h60, 1'b1, 16'(w));
		wr(8'h61, 1'b1, 16'(rr));
		on_cmd_in = 1'b1;
		wait_sig(0, 1'b1, (w + 2) * CPM, n);
		chk_rng("turn_on_wait", (w - 1) * CPM, w * CPM + 5, n);
		chk("ramp", 16'h0001, {15'h0000, ramp});
		wait_sig(1, 1'b0, (rr + 2) * CPM, n);
		chk_rng("ramp_time", (rr - 1) * CPM, rr * CPM + 5, n);
		$display("test turn-on done");

		wr(8'h5E, 1'b1, 16'h8000);
		wr(8'h5F, 1'b1, 16'h7000);
		vout_in = 16'h7FFF;
		repeat (2) @(negedge clk_in);
		chk("pg_below_on", 16'h0000, {15'h0000, pg});
		vout_in = 16'h8000;
		repeat (2) @(negedge clk_in);
		chk("pg_at_on", 16'h0001, {15'h0000, pg});
		vout_in = 16'h7000;
		repeat (2) @(negedge clk_in);
		chk("pg_at_off", 16'h0001, {15'h0000, pg});
		vout_in = 16'h6FFF;
		repeat (2) @(negedge clk_in);
		chk("pg_below_off", 16'h0000, {15'h0000, pg});
		chk("pg_status", 16'h0001, {15'h0000, pg_stat});
		clr(1'b1);
		@(negedge clk_in);
		chk("pg_status_clr", 16'h0000, {15'h0000, pg_stat});
		multi_pin_setup_pg_in = 1'b0;
		vout_in = 16'h9000;
		repeat (2) @(negedge clk_in);
		chk("pg_pin_off", 16'h0000, {15'h0000, pg});
		multi_pin_setup_pg_in = 1'b1;
		on_cmd_in = 1'b0;
		vout_in = 16'h0000;
		$display("test power good done");

		wr(8'h60, 1'b1, 16'h0001);
		wr(8'h61, 1'b1, 16'h0001);
		wr(8'h5A, 1'b0, 16'h0002);
		power_on();
		fault_in = 1'b1;
		repeat (6 * CPM) @(negedge clk_in);
		chk("ignore_mode", 16'h0001, {15'h0000, out_en});
		fault_in = 1'b0;
		wr(8'h5A, 1'b0, 16'h0042);
		fault_in = 1'b1;
		repeat (2 * CPM) @(negedge clk_in);
		fault_in = 1'b0;
		repeat (5 * CPM) @(negedge clk_in);
		chk("run_on_short", 16'h0001, {15'h0000, out_en});
		fault_in = 1'b1;
		wait_sig(0, 1'b0, 6 * CPM, n);
		chk_rng("run_on_time", 3 * CPM, 4 * CPM + 5, n);
		repeat (2) @(negedge clk_in);
		chk("no_retry_latch", 16'h0001, {15'h0000, latched});
		fault_in = 1'b0;
		clr(1'b0);
		@(negedge clk_in);
		chk("bit_clear", 16'h0000, {15'h0000, latched});
		on_cmd_in = 1'b0;
		wr(8'h5A, 1'b0, 16'h00C0);
		power_on();
		fault_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk("hold_latch", 16'h0001, {15'h0000, latched});
		chk("hold_off", 16'h0000, {15'h0000, out_en});
		fault_in = 1'b0;
		on_cmd_in = 1'b0;
		@(negedge clk_in);
		on_cmd_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk("off_on_clear", 16'h0000, {15'h0000, latched});
		on_cmd_in = 1'b0;
		$display("test response modes done");

		for (rr = 4; rr < 7; rr++)
		begin
			n = 1 + int'($urandom % 2);
			u = 1 + int'($urandom % 2);
			iv = (1 << n) * u;
			wr(8'hD2, 1'b0, 16'(u));
			wr(8'h5A, 1'b0, {8'h00, 2'b10, 3'(rr), 3'(n)});
			power_on();
			fault_in = 1'b1;
			prev = attempts;
			cnt = 0;
			last = 0;
			for (t = 0; t < 12 * iv * CPM && latched !== 1'b1; t++)
			begin
				@(negedge clk_in);
				if (attempts !== prev)
				begin
					if (cnt > 0)
						chk_rng("spacing", (iv - 1) * CPM, iv * CPM + 5, t - last);
					cnt++;
					last = t;
					prev = attempts;
				end
			end
			chk("gave_up", 16'h0001, {15'h0000, latched});
			if (latched !== 1'b1)
				conclude();
			chk_rng("restarts", rr, rr, cnt);
			chk("attempts", 16'(rr), {13'h0000, attempts});
			repeat (3 * iv * CPM) @(negedge clk_in);
			chk("stay_off", 16'h0000, {15'h0000, out_en});
			fault_in = 1'b0;
			clr(1'b1);
			@(negedge clk_in);
			chk("count_clear", 16'h0000, {13'h0000, attempts});
			on_cmd_in = 1'b0;
			@(negedge clk_in);
		end
		$display("test retry counts done");

		wr(8'h5A, 1'b0, 16'h00B9);
		power_on();
		fault_in = 1'b1;
		pe = out_en;
		cnt = 0;
		for (t = 0; t < 200 * CPM && cnt < 8; t++)
		begin
			@(negedge clk_in);
			if (out_en === 1'b1 && pe !== 1'b1)
				cnt++;
			pe = out_en;
		end
		chk_rng("endless", 8, 8, cnt);
		if (cnt < 8)
			conclude();
		chk("not_latched", 16'h0000, {15'h0000, latched});
		bias_ok_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk("bias_loss", 16'h0000, {15'h0000, out_en});
		bias_ok_in = 1'b1;
		other_fault_in = 1'b1;
		repeat (3) @(negedge clk_in);
		chk("other_fault", 16'h0001, {15'h0000, latched});
		chk("other_off", 16'h0000, {15'h0000, out_en});
		other_fault_in = 1'b0;
		fault_in = 1'b0;
		on_cmd_in = 1'b0;
		$display("test endless retry done");
		conclude();
	end
endmodule // tb_fault_retry_and_turn_on_sequencer
